// File: hw/dsp_core.sv
// Debug serial port front end: synchronisers, 35-bit shift engine, trap register.
// Assumes pins arrive asynchronously, the CPU side and reset-out run on clk.
// Function
// - Serial clock and data input pass two-flop synchronisers before use.
// - Each synced clock rising edge shifts input into LSB, MSB goes out.
// - Shift register is 35 bits, loaded serially, unloaded in parallel.
// - Clock may run freely; ready and start bits frame shifting.
// - Trap frames go to trap register in either mode; CPU frames go to CPU in debug mode only.
// - While in reset the output pin shows PLL lock, else shift data.
// - In debug mode CPU fetches and reads received words from shift register.
// - CPU write in debug mode parallel-loads the shift register for output.
// - Nine-bit trap register drives six traps, two breakpoints, vsync.
// - Self-clocked mode shifts one bit per system clock, tool syncs data.
// - Data input sampled eight clocks after reset-out negation selects mode.
// - Start search begins 16 clocks after negation, after input negates.
// - Serial clock pin sampled in reset enables debug, after reset requests entry.
// - Ready bit low when previous frame done; tool then sends start bit.
// - Length set means ten-bit trap frame, clear means 35-bit CPU frame.
// - Trap frame control bit picks trap enables or breakpoint bits.
`timescale 1ns/1ns
`default_nettype none
module dsp_core
    import dsp_pkg::*;
(
    input  wire logic                  clk,                // System clock, 100 MHz
    input  wire logic                  rst,                // Async reset, active high
    input  wire logic                  reset_out_signal,   // Processor held in reset
    input  wire logic                  pll_lock_indicator, // PLL lock, async level
    input  wire logic                  tool_serial_clock,  // Tool serial clock pin
    input  wire logic                  tool_serial_in,     // Tool serial data pin
    output logic                       tool_serial_out,    // Shared data out / lock pin
    input  wire logic                  freeze_status_pins, // Processor in debug mode
    output dsp_trap_t                  trap_enable_reg,    // Trap, breakpoint, vsync lines
    output logic                       cpu_rd_valid,       // Received word available
    input  wire logic                  cpu_rd_ready,       // CPU takes word
    output dsp_cpu_word_t              cpu_rd_word,        // Control bit and data
    input  wire logic                  cpu_wr,             // Debug data register write
    output logic                       cpu_wr_ready,       // Write accepted this cycle
    input  wire logic [CPU_DATA_W-1:0] cpu_wdata,          // Word to shift out
    output logic                       self_clocked,       // Selected clock mode
    output logic                       debug_enable,       // Strap caught during reset
    output logic                       debug_entry_req     // Entry request after reset
);
    typedef struct packed {
        dsp_fsm_t        fsm;
        logic [SR_W-1:0] sr;
        logic [5:0]      bitcnt;
        logic            len;
        logic [4:0]      post;
        logic            self_clk;
        logic            dbg_en;
        logic            dbg_entry;
        dsp_trap_t       trap;
        logic [1:0]      ck_sync;
        logic            ck_prev;
        logic [1:0]      din_sync;
        logic [1:0]      pll_sync;
    } dsp_state_t;

    dsp_state_t    s_q;
    dsp_state_t    s_d;
    logic          ck_s;
    logic          din_s;
    logic          strobe;
    logic          start;
    logic          len_now;
    logic          push;
    logic          fifo_ready;
    dsp_cpu_word_t push_word;

    // Idle image: ready low, status code, data ones
    function automatic logic [SR_W-1:0] idle_word(input logic [1:0] st);
        idle_word = {1'b0, st, {CPU_DATA_W{1'b1}}};
    endfunction

    // Frame length from the length bit
    function automatic logic [5:0] frame_len(input logic len);
        frame_len = len ? LEN_TRAP : LEN_CPU;
    endfunction

    // Second flops only; first flops feed nothing else
    assign ck_s  = s_q.ck_sync[1];
    assign din_s = s_q.din_sync[1];

    // One strobe for both modes; external edges need the clock at most half rate
    assign strobe  = s_q.self_clk ? 1'b1 : (ck_s && !s_q.ck_prev);
    assign start   = (s_q.fsm == DSP_SCAN) && strobe && din_s;
    assign len_now = (s_q.bitcnt == (BIT_LENGTH - 6'h01)) ? din_s : s_q.len;

    // Only debug-mode CPU frames go to the processor buffer
    assign push      = (s_q.fsm == DSP_XFER) && !s_q.len && freeze_status_pins;
    assign push_word = '{ctrl: s_q.sr[CF_CTRL_POS], data: s_q.sr[CPU_DATA_W-1:0]};

    // Writes land only while idle so a frame in flight is never corrupted
    assign cpu_wr_ready = (s_q.fsm == DSP_SCAN) && !start && freeze_status_pins;

    // Pin shows lock during reset, shift MSB afterwards
    assign tool_serial_out = reset_out_signal ? s_q.pll_sync[1] : s_q.sr[SR_MSB];

    assign trap_enable_reg = s_q.trap;
    assign self_clocked    = s_q.self_clk;
    assign debug_enable    = s_q.dbg_en;
    assign debug_entry_req = s_q.dbg_entry;

    // Next-state logic for the whole engine
    always_comb begin
        s_d          = s_q;
        s_d.ck_sync  = {s_q.ck_sync[0], tool_serial_clock};
        s_d.din_sync = {s_q.din_sync[0], tool_serial_in};
        s_d.pll_sync = {s_q.pll_sync[0], pll_lock_indicator};
        s_d.ck_prev  = ck_s;

        if (reset_out_signal) begin
            // Processor in reset: hold off, keep catching the debug strap
            s_d.fsm    = DSP_HOLD;
            s_d.post   = 5'h00;
            s_d.sr     = idle_word(ST_NULL);
            s_d.dbg_en = ck_s;
        end else begin
            // Count clocks after negation up to the scan holdoff
            if (s_q.post != SCAN_CLKS) begin
                s_d.post = s_q.post + 5'h01;
            end
            if (s_q.post == (MODE_CLKS - 5'h01)) begin
                s_d.self_clk  = din_s;
                s_d.dbg_entry = ck_s && s_q.dbg_en;
            end

            case (s_q.fsm)
                DSP_HOLD: begin
                    if (s_q.post == SCAN_CLKS) begin
                        s_d.fsm = din_s ? DSP_WAIT : DSP_SCAN;
                    end
                end
                DSP_WAIT: begin
                    if (!din_s) begin
                        s_d.fsm = DSP_SCAN;
                    end
                end
                DSP_SCAN: begin
                    if (start) begin
                        // Start bit enters LSB, ready bit leaves the MSB
                        s_d.sr     = {s_q.sr[SR_MSB-1:0], din_s};
                        s_d.bitcnt = 6'h01;
                        s_d.fsm    = DSP_SHIFT;
                    end else if (cpu_wr && cpu_wr_ready) begin
                        s_d.sr = {1'b0, ST_VALID, cpu_wdata};
                    end
                end
                DSP_SHIFT: begin
                    if (strobe) begin
                        s_d.sr     = {s_q.sr[SR_MSB-1:0], din_s};
                        s_d.bitcnt = s_q.bitcnt + 6'h01;
                        s_d.len    = len_now;
                        if ((s_q.bitcnt + 6'h01) == frame_len(len_now)) begin
                            s_d.fsm = DSP_XFER;
                        end
                    end
                end
                DSP_XFER: begin
                    if (push && !fifo_ready) begin
                        // Buffer full: keep ready high so the tool waits
                        s_d.sr[SR_MSB] = 1'b1;
                    end else begin
                        if (s_q.len) begin
                            if (!s_q.sr[TF_CTRL_POS]) begin
                                s_d.trap.ibus_te = s_q.sr[TF_IBUS_HI:TF_IBUS_LO];
                                s_d.trap.lbus_te = s_q.sr[TF_LBUS_HI:TF_LBUS_LO];
                                s_d.trap.vsync   = s_q.sr[TF_VSYNC_POS];
                            end else begin
                                s_d.trap.nmbrk = s_q.sr[TF_NMBRK_POS];
                                s_d.trap.mbrk  = s_q.sr[TF_MBRK_POS];
                            end
                        end
                        // CPU frame outside debug mode reports a sequencing error
                        s_d.sr  = idle_word((!s_q.len && !freeze_status_pins) ? ST_SEQ_ERR : ST_NULL);
                        s_d.fsm = DSP_SCAN;
                    end
                end
                default: begin
                    s_d.fsm = DSP_HOLD;
                end
            endcase
        end
    end

    // Whole state registered at once; reset idles the engine and clears traps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q          <= '0;
            s_q.fsm      <= DSP_HOLD;
            s_q.sr       <= {1'b0, ST_NULL, {CPU_DATA_W{1'b1}}};
        end else begin
            s_q <= s_d;
        end
    end

    // Receive buffer; its ready stalls the transfer state
    dsp_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_word),
        .out_valid (cpu_rd_valid),
        .out_ready (cpu_rd_ready),
        .out_data  (cpu_rd_word)
    );

    // Checks on the engine
    sequence start_s;
        s_q.fsm == DSP_SCAN && strobe && din_s && !reset_out_signal;
    endsequence

    sequence trap_frame_s;
        start_s ##1 (s_q.self_clk && din_s && s_q.fsm == DSP_SHIFT);
    endsequence

    start_taken_a: assert property (@(posedge clk) disable iff (rst)
        start_s |=> (s_q.fsm == DSP_SHIFT && s_q.bitcnt == 6'h01))
        else $error("start bit not taken");

    self_frame_a: assert property (@(posedge clk) disable iff (rst)
        trap_frame_s |-> ##9 (s_q.fsm == DSP_XFER))
        else $error("self-clocked trap frame not ten cycles");

    shift_lsb_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_SHIFT && strobe && !reset_out_signal)
        |=> (s_q.sr[0] == $past(din_s) && s_q.sr[SR_MSB:1] == $past(s_q.sr[SR_MSB-1:0])))
        else $error("shift did not move input into lsb");

    mode_sample_a: assert property (@(posedge clk) disable iff (rst)
        (!reset_out_signal && s_q.post == (MODE_CLKS - 5'h01)) |=> (s_q.self_clk == $past(din_s)))
        else $error("clock mode not sampled at eighth clock");

    scan_holdoff_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_SCAN || s_q.fsm == DSP_WAIT) |-> (s_q.post == SCAN_CLKS))
        else $error("scan began before holdoff");

    wait_negate_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_WAIT && din_s && !reset_out_signal) |=> (s_q.fsm == DSP_WAIT))
        else $error("scan began with input still high");

    ready_low_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_SCAN) |-> (s_q.sr[SR_MSB] == 1'b0))
        else $error("ready bit high while idle");

    pin_release_a: assert property (@(posedge clk) disable iff (rst)
        $fell(reset_out_signal) |-> (tool_serial_out == s_q.sr[SR_MSB] && s_q.fsm == DSP_HOLD))
        else $error("output pin not shift data after reset");

    trap_load_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_XFER && s_q.len && !s_q.sr[TF_CTRL_POS] && !reset_out_signal)
        |=> (s_q.trap.ibus_te == $past(s_q.sr[TF_IBUS_HI:TF_IBUS_LO])
             && $stable(s_q.trap.nmbrk)))
        else $error("trap enables not loaded");

    brk_load_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_XFER && s_q.len && s_q.sr[TF_CTRL_POS] && !reset_out_signal)
        |=> (s_q.trap.nmbrk == $past(s_q.sr[TF_NMBRK_POS]) && $stable(s_q.trap.ibus_te)))
        else $error("breakpoint bits not loaded");

    cpu_route_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_XFER && !s_q.len && !freeze_status_pins)
        |-> (!push ##1 s_q.sr[SR_MSB-1:SR_MSB-2] == ST_SEQ_ERR))
        else $error("cpu frame outside debug mode mishandled");

    cpu_load_a: assert property (@(posedge clk) disable iff (rst)
        (cpu_wr && cpu_wr_ready && !reset_out_signal)
        |=> (s_q.sr[CPU_DATA_W-1:0] == $past(cpu_wdata) && s_q.sr[SR_MSB] == 1'b0))
        else $error("debug data write did not load shift register");

    // Checks on reset hold, strap tracking, idle shifting, stall and routing
    hold_rearm_a: assert property (@(posedge clk) disable iff (rst)
        reset_out_signal |=> (s_q.fsm == DSP_HOLD && s_q.post == 5'h00))
        else $error("holdoff not restarted by processor reset");

    strap_track_a: assert property (@(posedge clk) disable iff (rst)
        reset_out_signal |=> (s_q.dbg_en == $past(ck_s)))
        else $error("debug strap not tracked during reset");

    no_strobe_hold_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_SHIFT && !strobe && !reset_out_signal)
        |=> $stable(s_q.sr))
        else $error("shift register moved without a strobe");

    stall_ready_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_XFER && push && !fifo_ready && !reset_out_signal)
        |=> (s_q.fsm == DSP_XFER && s_q.sr[SR_MSB] == 1'b1))
        else $error("ready bit not held high while buffer full");

    cpu_push_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.fsm == DSP_XFER && !s_q.len && freeze_status_pins && fifo_ready && !reset_out_signal)
        |=> (cpu_rd_valid && s_q.fsm == DSP_SCAN))
        else $error("debug cpu frame not handed to processor");
endmodule
`default_nettype wire

// File: hw/dsp_pkg.sv
// Shared constants and types for the debug serial port front end.
// Assumes a single system clock domain; pins are synchronised inside the core.
package dsp_pkg;

    // Shift register geometry
    localparam int          SR_W         = 35;
    localparam int          SR_MSB       = 34;
    localparam int          CPU_DATA_W   = 32;
    localparam int          TRAP_DATA_W  = 7;

    // Frame lengths in bits, start bit included; position of the length bit
    localparam logic [5:0]  LEN_TRAP     = 6'h0A;
    localparam logic [5:0]  LEN_CPU      = 6'h23;
    localparam logic [5:0]  BIT_LENGTH   = 6'h02;

    // Field positions after a trap frame (ten bits received)
    localparam int          TF_LEN_POS   = 8;
    localparam int          TF_CTRL_POS  = 7;
    localparam int          TF_IBUS_HI   = 6;
    localparam int          TF_IBUS_LO   = 3;
    localparam int          TF_LBUS_HI   = 2;
    localparam int          TF_LBUS_LO   = 1;
    localparam int          TF_VSYNC_POS = 0;
    localparam int          TF_NMBRK_POS = 6;
    localparam int          TF_MBRK_POS  = 5;

    // Field positions after a CPU frame (35 bits received)
    localparam int          CF_CTRL_POS  = 32;

    // Outgoing status codes
    localparam logic [1:0]  ST_VALID     = 2'h0;
    localparam logic [1:0]  ST_SEQ_ERR   = 2'h1;
    localparam logic [1:0]  ST_NULL      = 2'h3;

    // System clock rate, and timing after reset-out negation in system clocks
    localparam int          SYS_CLK_MHZ  = 100;
    localparam logic [4:0]  MODE_CLKS    = 5'h08;
    localparam logic [4:0]  SCAN_CLKS    = 5'h10;

    // Receive buffer towards the processor
    localparam int          FIFO_W       = CPU_DATA_W + 1;
    localparam int          FIFO_DEPTH   = 32;

    // Serial engine states, Gray along hold, wait, scan, shift, transfer
    typedef enum logic [2:0] {
        DSP_HOLD  = 3'h0,
        DSP_WAIT  = 3'h1,
        DSP_SCAN  = 3'h3,
        DSP_SHIFT = 3'h2,
        DSP_XFER  = 3'h6
    } dsp_fsm_t;

    // Nine-bit trap enable register
    typedef struct packed {
        logic [3:0] ibus_te;
        logic [1:0] lbus_te;
        logic       vsync;
        logic       nmbrk;
        logic       mbrk;
    } dsp_trap_t;

    // Word handed to the processor
    typedef struct packed {
        logic                  ctrl;
        logic [CPU_DATA_W-1:0] data;
    } dsp_cpu_word_t;

endpackage

// File: hw/dsp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; full and empty come from pointers with a wrap bit.
`timescale 1ns/1ns
`default_nettype none
module dsp_fifo #(
    parameter int W     = 33,
    parameter int DEPTH = 32
) (
    input  wire logic         clk,       // System clock
    input  wire logic         rst,       // Async reset, active high
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Space available
    input  wire logic [W-1:0] in_data,   // Write word
    output logic              out_valid, // Word available
    input  wire logic         out_ready, // Reader takes word
    output logic [W-1:0]      out_data   // Oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             wp;
        logic [AW:0]             rp;
    } dsp_fifo_state_t;

    dsp_fifo_state_t s_q;
    dsp_fifo_state_t s_d;
    logic            full;
    logic            empty;

    // Wrap bits differ and indices match only when full
    assign full      = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
    assign empty     = (s_q.wp == s_q.rp);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = s_q.mem[s_q.rp[AW-1:0]];

    // Pointer and storage update
    always_comb begin
        s_d = s_q;
        if (in_valid && !full) begin
            s_d.mem[s_q.wp[AW-1:0]] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            s_d.rp = s_q.rp + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule
`default_nettype wire

// File: test/dsp_tool.sv
// Behavioural development tool on the far side of the serial port.
// Assumes the bench calls its tasks from one process; idle lines sit low as if pulled down.
`timescale 1ns/1ns
`default_nettype none
module dsp_tool (
    input  wire logic clk,     // System clock, paces self-clocked frames
    output logic      ser_clk, // Serial clock pin
    output logic      ser_in,  // Serial data pin
    input  wire logic ser_out  // Shared data out pin
);
    initial begin
        ser_clk = 1'b0;
        ser_in  = 1'b0;
    end

    // Straps held on the pins around reset
    task automatic strap(input logic c, input logic d);
        ser_clk <= c;
        ser_in  <= d;
    endtask

    // One frame MSB first, driven on system clock edges; serial clock period is 80 ns
    task automatic xfer(input logic [34:0] w, input int n, input bit self, output logic [34:0] got);
        got = 35'h0;
        for (int k = 0; k < 400 && !self && ser_out !== 1'b0; k++) @(posedge clk);
        for (int i = 0; i < n + 2; i++) begin
            if (self) begin
                // Pins reach the engine two clocks late, so output lags input by two bits
                @(posedge clk);
                if (i < n) ser_in <= w[34-i];
                else if (i == n) ser_in <= 1'b0;
                @(negedge clk);
                if (i >= 2) got[36-i] = ser_out;
            end else if (i < n) begin
                ser_in <= w[34-i];
                repeat (4) @(posedge clk);
                got[34-i] = ser_out;
                ser_clk <= 1'b1;
                repeat (4) @(posedge clk);
                ser_clk <= 1'b0;
            end
        end
        if (!self) ser_in <= 1'b0; // Released line falls to its pull-down
    endtask
endmodule
`default_nettype wire

// File: test/debug_serial_port_front_end_test.sv
// Self-checking bench for the debug serial port front end.
// Assumes dsp_pkg, dsp_fifo, dsp_core and the tool model dsp_tool are compiled first.
`timescale 1ns/1ns
`default_nettype none
module debug_serial_port_front_end_test
    import dsp_pkg::*;
;
    localparam logic [34:0] IDLE_NULL = 35'h3FFFFFFFF;
    localparam logic [34:0] IDLE_SEQ  = 35'h1FFFFFFFF;
    localparam logic [34:0] TRAP_MASK = 35'h7FE000000;

    logic                  clk;
    logic                  rst;
    logic                  reset_out_signal;
    logic                  pll_lock_indicator;
    logic                  freeze_status_pins;
    logic                  cpu_rd_ready;
    logic                  cpu_wr;
    logic [CPU_DATA_W-1:0] cpu_wdata;
    logic                  ser_clk;
    logic                  ser_in;
    logic                  tool_serial_out;
    dsp_trap_t             trap_enable_reg;
    logic                  cpu_rd_valid;
    dsp_cpu_word_t         cpu_rd_word;
    logic                  cpu_wr_ready;
    logic                  self_clocked;
    logic                  debug_enable;
    logic                  debug_entry_req;
    logic [8:0]            trap_m;
    logic [34:0]           exp_out;
    logic [32:0]           q[$];
    logic [15:0]           seed = 16'h0031;
    int                    fails = 0;
    int                    tests_run = 0;

    dsp_core uut (
        .clk                (clk),
        .rst                (rst),
        .reset_out_signal   (reset_out_signal),
        .pll_lock_indicator (pll_lock_indicator),
        .tool_serial_clock  (ser_clk),
        .tool_serial_in     (ser_in),
        .tool_serial_out    (tool_serial_out),
        .freeze_status_pins (freeze_status_pins),
        .trap_enable_reg    (trap_enable_reg),
        .cpu_rd_valid       (cpu_rd_valid),
        .cpu_rd_ready       (cpu_rd_ready),
        .cpu_rd_word        (cpu_rd_word),
        .cpu_wr             (cpu_wr),
        .cpu_wr_ready       (cpu_wr_ready),
        .cpu_wdata          (cpu_wdata),
        .self_clocked       (self_clocked),
        .debug_enable       (debug_enable),
        .debug_entry_req    (debug_entry_req)
    );

    dsp_tool tool (
        .clk     (clk),
        .ser_clk (ser_clk),
        .ser_in  (ser_in),
        .ser_out (tool_serial_out)
    );

    // System clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog: roughly five times the expected run
    initial begin
        #600000;
        fails++;
        tally_and_finish();
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] rnd();
        logic [15:0] a;
        seed = lfsr(seed);
        a    = seed;
        seed = lfsr(seed);
        return {a, seed};
    endfunction

    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (fails == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Reset with straps; the straps stay past the holdoff, so a high mode strap tests the wait
    task automatic boot(input logic mode, input logic dbg);
        rst              <= 1'b1;
        reset_out_signal <= 1'b1;
        tool.strap(dbg, mode);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int b = 0; b < 2; b++) begin
            pll_lock_indicator <= b[0];
            repeat (4) @(posedge clk);
            check({34'h0, tool_serial_out}, {34'h0, b[0]});
        end
        check({26'h0, trap_enable_reg}, 35'h0);
        reset_out_signal <= 1'b0;
        repeat (25) @(posedge clk);
        check({34'h0, self_clocked}, {34'h0, mode});
        check({33'h0, debug_enable, debug_entry_req}, {33'h0, dbg, dbg});
        tool.strap(1'b0, 1'b0);
        repeat (10) @(posedge clk);
        trap_m  = 9'h0;
        exp_out = IDLE_NULL;
        q.delete();
    endtask

    // One frame through the tool, then the reference model is advanced
    task automatic frame(input logic len, input logic ctrl, input bit self);
        logic [31:0] d;
        logic [34:0] got;
        logic [34:0] m;
        d = rnd();
        if (len && ctrl) d[29:25] = 5'h1F;
        m = len ? TRAP_MASK : {35{1'b1}};
        tool.xfer({1'b1, len, ctrl, d}, len ? 10 : 35, self, got);
        check(got & m, exp_out & m);
        repeat (20) @(posedge clk);
        exp_out = IDLE_NULL;
        if (len && !ctrl) trap_m[8:2] = d[31:25];
        else if (len) trap_m[1:0] = d[31:30];
        else if (freeze_status_pins) q.push_back({ctrl, d});
        else exp_out = IDLE_SEQ;
        check({26'h0, trap_enable_reg}, {26'h0, trap_m});
    endtask

    // Processor write of the data register; held until the accepting edge
    task automatic cpu_write();
        logic [31:0] wd;
        wd = rnd();
        cpu_wdata <= wd;
        cpu_wr    <= 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            if (cpu_wr_ready === 1'b1) break;
        end
        cpu_wr  <= 1'b0;
        exp_out = {3'b000, wd};
    endtask

    // Processor reads every queued word in order
    task automatic drain();
        while (q.size() > 0) begin
            for (int k = 0; k < 50 && cpu_rd_valid !== 1'b1; k++) @(posedge clk);
            check({2'b0, cpu_rd_word}, {2'b0, q.pop_front()});
            cpu_rd_ready <= 1'b1;
            @(posedge clk);
            cpu_rd_ready <= 1'b0;
            @(posedge clk);
        end
        check({34'h0, cpu_rd_valid}, 35'h0);
    endtask

    // Main sequence
    initial begin
        rst                = 1'b1;
        reset_out_signal   = 1'b1;
        pll_lock_indicator = 1'b0;
        freeze_status_pins = 1'b0;
        cpu_rd_ready       = 1'b0;
        cpu_wr             = 1'b0;
        cpu_wdata          = 32'h0;
        boot(1'b0, 1'b1);
        for (int i = 0; i < 6; i++) frame(1'b1, i[0], 1'b0);
        // CPU frames outside debug mode are dropped and flagged
        frame(1'b0, 1'b1, 1'b0);
        frame(1'b0, 1'b0, 1'b0);
        check({34'h0, cpu_rd_valid}, 35'h0);
        freeze_status_pins <= 1'b1;
        @(posedge clk);
        cpu_write();
        frame(1'b1, 1'b1, 1'b0);
        // Overfill the receive buffer while the processor stalls
        for (int i = 0; i < 33; i++) frame(1'b0, i[1], 1'b0);
        check({34'h0, tool_serial_out}, {34'h0, 1'b1});
        drain();
        frame(1'b1, 1'b0, 1'b0);
        // Second reset mid-run selects self-clocked mode
        freeze_status_pins <= 1'b0;
        boot(1'b1, 1'b0);
        for (int i = 0; i < 4; i++) frame(1'b1, i[0], 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
